// ---- hw/acz_pkg.sv ----
// package: field layout, reset values and shared types of the converter config block
package acz_pkg;
	localparam int unsigned DATA_W        = 12;
	localparam int unsigned REG_W         = 10;
	localparam logic [1:0]  ADDR_CFG_ZERO = 2'h0;
	localparam int unsigned POS_VREF      = 0;
	localparam int unsigned POS_MODE      = 1;
	localparam int unsigned POS_SLEEP     = 2;
	localparam int unsigned POS_PICK      = 3;
	localparam int unsigned POS_PAIR      = 5;
	localparam int unsigned POS_SCAN      = 7;
	localparam int unsigned POS_TEST      = 8;
	localparam logic [9:0]  CFG_RESET     = 10'h020;
	localparam logic [3:0]  TRIG_RESET    = 4'h1;

	typedef enum logic [1:0] {
		ACZ_AINP,
		ACZ_AINM,
		ACZ_BINP,
		ACZ_BINM
	} acz_input_type;

	typedef struct packed {
		logic [1:0] test_volt_sel;
		logic       scan_enable;
		logic [1:0] pair_count;
		logic [1:0] input_pick;
		logic       sleep_ctl;
		logic       single_mode;
		logic       ext_ref;
	} acz_cfg_type;

	typedef struct packed {
		logic [11:0] data;
		logic [2:0]  chan;
		logic        diff;
	} acz_word_type;
endpackage

// ---- hw/acz_control.sv ----
// converter control register zero with conversion sequencing and data-available logic
// Notes on behaviour
// - Bit 0 selects internal reference at 0, external at 1; resets 0.
// - Bit 1 at 0 selects continuous mode, pin is a conversion clock.
// - Continuous mode: one result into the FIFO per conversion clock falling edge that finds a free entry.
// - Bit 1 at 1 makes the pin a start input; host pulses it.
// - Single mode: start falling edge holds all selected inputs, then sequence converts.
// - Data-available asserts once the trigger condition is met.
// - Bit 2 at 1 powers the converter down; resets 0.
// - Register writes and reads still work while powered down.
// - Stored results may still be read while powered down.
// - Bits 3-4 choose the analog input channel; reset 0.
// - Bits 5-6 give the differential channel count; reset bit5=1, bit6=0.
// - Bit 7 switches autoscan on or off; resets 0.
// - Bits 8-9 select one of three test voltages; 0 is normal.
// - Data-available stays inactive in test mode; host reads without it.
// - Write this register with address lines 00 and value on low ten bits.
// - Four-input autoscan order is AINP, AINM, BINP, BINM, repeating.
// - Trigger is met when results written reach or exceed the programmed trigger level.
`timescale 1ns/1ps
module acz_control (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 reset,
	// register write port
	input  wire logic                 reg_write,
	input  wire logic                 reg_addr_line_lo,
	input  wire logic                 reg_addr_line_hi,
	input  wire logic [9:0]           reg_wdata,
	input  wire logic [3:0]           trigger_level,
	// conversion pin and analog core
	input  wire logic                 conversion_clock_pin,
	input  wire logic [11:0]          core_sample,
	// result stream out
	output logic                      word_valid,
	input  wire logic                 word_ready,
	output acz_pkg::acz_word_type     word_out,
	// status
	output acz_pkg::acz_cfg_type      config_out,
	output logic [1:0]                pick_out,
	output logic                      hold_out,
	output logic                      block_ready_flag
);
	typedef struct packed {
		logic                  pin_s1;
		logic                  pin_s2;
		logic                  pin_s3;
		acz_pkg::acz_cfg_type  cfg;
		acz_pkg::acz_cfg_type  run;
		logic                  busy;
		logic                  hold;
		logic [1:0]            step;
		logic [1:0]            pick;
		logic [3:0]            count;
		logic                  ready_flag;
		logic [1:0]            buf_valid;
		acz_pkg::acz_word_type buf0;
		acz_pkg::acz_word_type buf1;
	} acz_state_type;

	acz_state_type state_reg;
	acz_state_type state_next;

	logic                  fall;
	logic                  valid_sel;
	logic [1:0]            seq_len;
	logic [2:0]            seq_chan;
	logic                  seq_diff;
	logic                  push;
	logic                  pop;
	logic                  last_step;
	acz_pkg::acz_word_type new_word;

	// decode of the active config into sequence length and per-step channel
	always_comb begin
		valid_sel = 1'b1;
		seq_len   = 2'h0;
		seq_chan  = {1'b0, state_reg.step};
		seq_diff  = 1'b0;
		unique case ({state_reg.run.scan_enable, state_reg.run.pair_count,
			state_reg.run.input_pick})
			5'h00, 5'h01, 5'h02, 5'h03: begin
				seq_chan = {1'b0, state_reg.run.input_pick};
			end
			5'h04, 5'h05: begin
				seq_diff = 1'b1;
				seq_chan = {1'b0, state_reg.run.input_pick[0], 1'b0};
			end
			5'h11, 5'h12, 5'h13: begin
				// fixed scan order, one step per input
				seq_len = state_reg.run.input_pick;
			end
			5'h15: begin
				seq_len  = 2'h1;
				seq_diff = state_reg.step[0];
				seq_chan = state_reg.step[0] ? 3'h2 : 3'h0;
			end
			5'h16: begin
				seq_len  = 2'h2;
				seq_diff = (state_reg.step == 2'h2);
				seq_chan = {1'b0, state_reg.step};
			end
			5'h19: begin
				seq_len  = 2'h1;
				seq_diff = 1'b1;
				seq_chan = {1'b0, state_reg.step[0], 1'b0};
			end
			default: begin
				valid_sel = 1'b0;
			end
		endcase
	end

	assign fall      = state_reg.pin_s3 & ~state_reg.pin_s2;
	assign last_step = (state_reg.step == seq_len);
	assign pop       = state_reg.buf_valid[0] & word_ready;
	assign new_word  = '{data: core_sample, chan: seq_chan, diff: seq_diff};
	// converter idle when asleep or configured illegally; a full buffer stalls pushing
	assign push = ~state_reg.run.sleep_ctl & valid_sel & ~state_reg.buf_valid[1] &
		(state_reg.run.single_mode ? state_reg.busy : fall);

	always_comb begin
		state_next        = state_reg;
		state_next.pin_s1 = conversion_clock_pin;
		state_next.pin_s2 = state_reg.pin_s1;
		state_next.pin_s3 = state_reg.pin_s2;

		// writes accepted regardless of sleep state
		if (reg_write && {reg_addr_line_hi, reg_addr_line_lo} == acz_pkg::ADDR_CFG_ZERO) begin
			state_next.cfg = reg_wdata;
		end
		// config latched only while no single-mode sequence is busy, so that sequence stays coherent
		if (!state_reg.busy) begin
			state_next.run = state_reg.cfg;
		end

		if (state_reg.run.single_mode && !state_reg.busy && fall &&
			!state_reg.run.sleep_ctl) begin
			state_next.busy = 1'b1;
			state_next.hold = 1'b1;
			state_next.step = 2'h0;
		end

		if (push) begin
			if (last_step) begin
				state_next.step = 2'h0;
				state_next.busy = 1'b0;
				state_next.hold = 1'b0;
			end else begin
				state_next.step = state_reg.step + 2'h1;
			end
		end else if (!valid_sel || state_reg.run.sleep_ctl) begin
			state_next.busy = 1'b0;
			state_next.hold = 1'b0;
		end
		state_next.pick = seq_chan[1:0];

		// two-entry buffer; reads run during sleep as well
		unique case ({push, pop})
			2'b10: begin
				if (state_reg.buf_valid[0]) begin
					state_next.buf1      = new_word;
					state_next.buf_valid = 2'b11;
				end else begin
					state_next.buf0      = new_word;
					state_next.buf_valid = 2'b01;
				end
			end
			2'b01: begin
				state_next.buf0      = state_reg.buf1;
				state_next.buf_valid = {1'b0, state_reg.buf_valid[1]};
			end
			2'b11: begin
				if (state_reg.buf_valid[1]) begin
					state_next.buf0 = state_reg.buf1;
					state_next.buf1 = new_word;
				end else begin
					state_next.buf0 = new_word;
				end
			end
			2'b00: begin
			end
		endcase

		// data-available: one-cycle flag per block of trigger_level results
		state_next.ready_flag = 1'b0;
		if (push) begin
			if (state_reg.count + 4'h1 >= trigger_level) begin
				state_next.count      = 4'h0;
				state_next.ready_flag = (state_reg.run.test_volt_sel == 2'h0);
			end else begin
				state_next.count = state_reg.count + 4'h1;
			end
		end

		if (reset) begin
			state_next            = '0;
			state_next.cfg        = acz_pkg::CFG_RESET;
			state_next.run        = acz_pkg::CFG_RESET;
		end
	end

	always_ff @(posedge clock) begin
		state_reg <= state_next;
	end

	assign word_valid       = state_reg.buf_valid[0];
	assign word_out         = state_reg.buf0;
	assign config_out       = state_reg.cfg;
	assign pick_out         = state_reg.pick;
	assign hold_out         = state_reg.hold;
	assign block_ready_flag = state_reg.ready_flag;
endmodule

// ---- verif/acz_monitor.sv ----
// checker: register, stream and flag relations at the control block's ports
`timescale 1ns/1ps
module acz_monitor (
	// clock and reset
	input wire logic			clock,
	input wire logic			reset,
	// register write
	input wire logic			reg_write,
	input wire logic			reg_addr_line_lo,
	input wire logic			reg_addr_line_hi,
	input wire logic [9:0]			reg_wdata,
	// pin and stream
	input wire logic			conversion_clock_pin,
	input wire logic			word_valid,
	input wire logic			word_ready,
	input wire acz_pkg::acz_word_type	word_out,
	// status
	input wire acz_pkg::acz_cfg_type	config_out,
	input wire logic			hold_out,
	input wire logic			block_ready_flag
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	wire wr0 = reg_write && !reg_addr_line_lo && !reg_addr_line_hi;
	// plain continuous single-input setup, awake, with no scan, pairs or test voltage
	wire plain = !config_out.single_mode && !config_out.sleep_ctl && config_out[9:5] == 5'h00;

	a_reset_value: assert property (disable iff (1'b0) reset |=> config_out == 10'h020)
		else $error("config not at reset value");
	a_write_taken: assert property (wr0 |=> config_out == $past(reg_wdata))
		else $error("config write not taken");
	a_config_keeps: assert property (!wr0 |=> $stable(config_out))
		else $error("config changed without a write");
	a_word_holds: assert property (word_valid && !word_ready |=> word_valid && $stable(word_out))
		else $error("stalled word lost or changed");
	a_test_quiet: assert property (config_out[9:8] != 2'h0 && $past(config_out[9:8]) != 2'h0
		|-> !block_ready_flag)
		else $error("flag raised in test mode");
	a_hold_single: assert property (hold_out |-> config_out.single_mode)
		else $error("hold outside single mode");
	a_sleep_quiet: assert property (config_out.sleep_ctl && $past(config_out.sleep_ctl, 8)
		&& !word_valid |=> !word_valid)
		else $error("word produced while asleep");
	a_clock_answer: assert property ($fell(conversion_clock_pin) && plain && !word_valid
		&& word_ready |-> ##[2:6] word_valid)
		else $error("no word after conversion clock edge");

	c_flag: cover property (block_ready_flag);
	c_hold: cover property (hold_out);
	c_stall: cover property (word_valid && !word_ready);
endmodule

bind acz_control acz_monitor MON (.clock, .reset, .reg_write, .reg_addr_line_lo,
	.reg_addr_line_hi, .reg_wdata, .conversion_clock_pin, .word_valid, .word_ready,
	.word_out, .config_out, .hold_out, .block_ready_flag);

// ---- verif/acz_host_model.sv ----
// host side: drives the conversion pin and pops result words
`timescale 1ns/1ps
module acz_host_model (
	// clock
	input wire logic	clock,
	// stall request from the bench
	input wire logic	stall,
	// pins toward the block
	output logic		conversion_clock_pin,
	output logic		word_ready
);
	// pin idles high: the conversion clock stands still between bursts
	initial conversion_clock_pin = 1'b1;
	// results popped without waiting for the flag
	assign word_ready = !stall;
	task automatic pulse();
		repeat (3) @(posedge clock);
		#2 conversion_clock_pin = 1'b0;
		repeat (3) @(posedge clock);
		#2 conversion_clock_pin = 1'b1;
	endtask
endmodule

// ---- verif/tb.sv ----
// testbench: config register, conversions, buffer stall, sleep, test mode, autoscan
`timescale 1ns/1ps
module tb;
	logic			clock = 0, reset = 1, reg_write = 0, lo = 0, hi = 0, stall = 0;
	logic [9:0]		reg_wdata = '0;
	logic [3:0]		trigger_level = 4'h1;
	logic [11:0]		core_sample = 12'hA5C;
	logic			pin, word_valid, word_ready, hold_out, flag;
	logic [1:0]		pick_out;
	acz_pkg::acz_word_type	word_out;
	acz_pkg::acz_cfg_type	config_out;
	acz_pkg::acz_word_type	got[$];
	int			num_errors = 0, total_checks = 0, flags = 0, holds = 0;

	acz_host_model HOST (.clock(clock), .stall(stall), .conversion_clock_pin(pin),
		.word_ready(word_ready));
	acz_control DUT (.clock(clock), .reset(reset), .reg_write(reg_write),
		.reg_addr_line_lo(lo), .reg_addr_line_hi(hi), .reg_wdata(reg_wdata),
		.trigger_level(trigger_level), .conversion_clock_pin(pin),
		.core_sample(core_sample), .word_valid(word_valid), .word_ready(word_ready),
		.word_out(word_out), .config_out(config_out), .pick_out(pick_out),
		.hold_out(hold_out), .block_ready_flag(flag));

	always #10 clock = ~clock;
	always @(posedge clock) begin
		if (word_valid === 1'b1 && word_ready)
			got.push_back(word_out);
		if (flag === 1'b1)
			flags++;
		if (hold_out === 1'b1)
			holds++;
	end

	task check(input logic [15:0] act, input logic [15:0] exp, input string msg);
		total_checks++;
		if (act !== exp) begin
			num_errors++;
			$display("ERROR %0t %s: got %h want %h", $time, msg, act, exp);
		end
	endtask
	task wr(input logic [1:0] a, input logic [9:0] v);
		@(posedge clock);
		#2 {hi, lo} = a;
		reg_wdata = v;
		reg_write = 1;
		@(posedge clock);
		#2 reg_write = 0;
	endtask
	task conv(input int n);
		got.delete();
		flags = 0;
		holds = 0;
		repeat (n) HOST.pulse();
		repeat (12) @(posedge clock);
		// leave off the edge so the caller's next drive cannot race it
		#2;
	endtask
	task summarize();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task t_regs();
		check(config_out, 10'h020, "reset value");
		for (int a = 1; a < 4; a++)
			wr(a[1:0], 10'h3FF);
		check(config_out, 10'h020, "foreign address");
		wr(2'h0, 10'h001);
		check(config_out, 10'h001, "reference select");
		wr(2'h0, 10'h010);
		check(config_out, 10'h010, "write");
	endtask
	task t_cont();
		conv(1);
		check(got.size(), 1, "words");
		check(got[0].data, core_sample, "data");
		check(got[0].chan[1:0], 2'h2, "channel");
		check(pick_out, 2'h2, "pick");
		check(flags, 1, "flag");
		stall = 1;
		conv(3);
		stall = 0;
		repeat (6) @(posedge clock);
		check(got.size(), 2, "buffer depth");
	endtask
	task t_sleep();
		stall = 1;
		conv(1);
		wr(2'h0, 10'h014);
		check(config_out, 10'h014, "write asleep");
		stall = 0;
		repeat (6) @(posedge clock);
		check(got.size(), 1, "read asleep");
		conv(1);
		check(got.size(), 0, "asleep");
	endtask
	task t_test();
		wr(2'h0, 10'h110);
		conv(2);
		check(flags, 0, "test flag");
		wr(2'h0, 10'h010);
		conv(1);
		check(flags, 1, "normal again");
	endtask
	task t_scan();
		trigger_level = 4'h4;
		wr(2'h0, 10'h09A);
		conv(1);
		check(got.size(), 4, "scan words");
		foreach (got[i])
			check(got[i].chan[1:0], i[1:0], "scan order");
		check(flags, 1, "block flag");
		check(holds, 4, "hold span");
	endtask

	initial begin
		repeat (5) @(posedge clock);
		#2 reset = 0;
		t_regs();
		t_cont();
		t_sleep();
		t_test();
		t_scan();
		summarize();
	end
	initial begin
		#100000;
		num_errors++;
		summarize();
	end
endmodule
